// [ddc_pkg.sv]
// Shared constants of the half-band decimation chain: register map,
// control field layout and fixed filter coefficient tables.
// Assumes a Wishbone slave with byte addresses and 32-bit data.
package ddc_pkg;

	// Register map, byte addresses
	localparam logic [11:0] DDC_CTRL0_ADDR  = 12'h310;
	localparam logic [11:0] DDC_CTRL1_ADDR  = 12'h330;
	localparam logic [11:0] DDC_STAT0_ADDR  = 12'h31C;
	localparam logic [11:0] DDC_STAT1_ADDR  = 12'h33C;

	// Control field positions
	localparam int DDC_SEL_LSB   = 0;
	localparam int DDC_C2R_BIT   = 3;
	localparam int DDC_GAIN_BIT  = 6;
	localparam int DDC_CPLX_BIT  = 7;
	localparam logic [7:0] DDC_CTRL_MASK  = 8'hCB;
	localparam logic [7:0] DDC_CTRL_RESET = 8'h00;

	// Decimation select codes
	localparam logic [1:0] DDC_SEL_FINAL_ONLY = 2'h3;
	localparam logic [1:0] DDC_SEL_THIRD      = 2'h0;
	localparam logic [1:0] DDC_SEL_SECOND     = 2'h1;
	localparam logic [1:0] DDC_SEL_ALL        = 2'h2;

	// Status field positions
	localparam int DDC_STAT_CNT_LSB = 16;

	// Half-band tables: outer tap first, centre tap last
	localparam int DDC_FIRST_TAPS  = 11;
	localparam int DDC_FIRST_SHIFT = 9;
	localparam int DDC_FIRST_COEF [6]  = '{3, 0, -25, 0, 150, 256};
	localparam int DDC_SECOND_TAPS  = 11;
	localparam int DDC_SECOND_SHIFT = 9;
	localparam int DDC_SECOND_COEF [6] = '{3, 0, -25, 0, 150, 256};
	localparam int DDC_THIRD_TAPS  = 19;
	localparam int DDC_THIRD_SHIFT = 18;
	localparam int DDC_THIRD_COEF [10] = '{161, 0, -1328, 0, 5814, 0,
		-19272, 0, 80160, 131072};
	localparam int DDC_FINAL_TAPS  = 55;
	localparam int DDC_FINAL_SHIFT = 20;
	localparam int DDC_FINAL_COEF [28] = '{-24, 0, 102, 0, -302, 0, 730,
		0, -1544, 0, 2964, 0, -5284, 0, 8903, 0, -14383, 0, 22640, 0,
		-35476, 0, 57468, 0, -105442, 0, 331792, 524288};

	// Clamp to a signed range of w bits
	function automatic longint ddc_clamp(input longint v, input int w);
		longint hi;
		longint lo;
		hi = (longint'(1) <<< (w - 1)) - longint'(1);
		lo = -(longint'(1) <<< (w - 1));
		if (v > hi) begin
			return hi;
		end else if (v < lo) begin
			return lo;
		end
		return v;
	endfunction

endpackage

// [ddc_chain.sv]
// What this block does
// [RULE_01] Four decimate-by-two half-band stages in fixed order first to final.
// [RULE_02] Final stage is always active, no bypass.
// [RULE_03] First stage is an 11-tap symmetric fixed filter.
// [RULE_04] First stage on only for complex 16 or real 8 decimation.
// [RULE_05] Second stage is an 11-tap symmetric fixed filter.
// [RULE_06] Second stage on for complex 8/16 or real 4/8.
// [RULE_07] Third stage is a 19-tap symmetric fixed filter.
// [RULE_08] Third stage on for complex 4/8/16 or real 2/4/8.
// [RULE_09] Third stage uses the given 19-bit symmetric coefficients.
// [RULE_10] Final stage is a 55-tap symmetric fixed filter.
// [RULE_11] Final stage uses the given 21-bit symmetric coefficients.
// [RULE_12] Per-channel selectable gain of 0 dB or 6 dB.
// [RULE_13] Software should pick 6 dB when real input is mixed down.
// [RULE_14] Complex-to-real mode keeps final filtering but skips its downsample.
// [RULE_15] Complex-to-real adds a quarter-rate upconverting complex mixer.
// [RULE_16] After upconversion only the in-phase part is output.
// [RULE_17] Two-bit decimation select in low bits of per-channel control register.
// [RULE_18] Bit 7 of the control register selects real or complex input.
// [RULE_19] Bypassed stage passes samples unchanged; first two tables are parameters.
// [RULE_20] Active stage outputs one valid sample per two inputs; in complex-to-real mode the final stage outputs one per input.
//
// One channel of the half-band chain with its control register on
// classic Wishbone. Assumes mixer samples arrive on i_core_clk.
`timescale 1ns/1ps

module ddc_hb_stage #(
	parameter int W     = 16,
	parameter int NTAPS = 11,
	parameter int SHIFT = 9,
	parameter int COEF [(NTAPS + 1) / 2] = '{default: 0}
) (
	// Clock and reset
	input  wire logic                i_core_clk,
	input  wire logic                i_rst_n,
	// Mode
	input  wire logic                i_enable,
	input  wire logic                i_decimate,
	// Sample in
	input  wire logic                i_valid,
	input  wire logic signed [W-1:0] i_data,
	// Sample out
	output logic                     o_valid,
	output logic signed [W-1:0]      o_data
);
	localparam int HALF = (NTAPS + 1) / 2;

	// Fold needs an odd tap count and a rounding bit
	if (NTAPS < 3 || NTAPS % 2 == 0) begin : g_taps_check
		$error("ddc_hb_stage: NTAPS must be odd and at least 3");
	end
	if (SHIFT < 1 || SHIFT > 40) begin : g_shift_check
		$error("ddc_hb_stage: SHIFT must lie in 1..40");
	end
	if (W < 2 || W > 32) begin : g_width_check
		$error("ddc_hb_stage: W must lie in 2..32");
	end

	// Taps keep only accepted samples; history survives a mode change
	logic signed [W-1:0] taps [NTAPS];
	logic                phase;
	logic                pend;
	logic signed [W-1:0] next_filt;

	// Symmetric fold halves the multiplier count
	always_comb begin
		longint acc;
		acc = '0;
		for (int k = 0; k < HALF - 1; k++) begin
			acc = acc + longint'(COEF[k]) *
				(longint'(taps[k]) + longint'(taps[NTAPS - 1 - k]));
		end
		acc = acc + longint'(COEF[HALF - 1]) * longint'(taps[HALF - 1]);
		acc = (acc + (longint'(1) <<< (SHIFT - 1))) >>> SHIFT;
		next_filt = W'(ddc_pkg::ddc_clamp(acc, W));
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			for (int k = 0; k < NTAPS; k++) begin
				taps[k] <= '0;
			end
		end else if (i_valid && i_enable) begin
			taps[0] <= i_data;
			for (int k = 1; k < NTAPS; k++) begin
				taps[k] <= taps[k - 1];
			end
		end
	end

	// Keep every second filtered sample when decimating
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n || !i_enable) begin
			phase <= 1'b0;
			pend  <= 1'b0;
		end else begin
			pend <= i_valid && (!i_decimate || phase); // [RULE_20]
			if (i_valid) begin
				phase <= ~phase;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_valid <= 1'b0;
			o_data  <= '0;
		end else if (i_enable) begin
			o_valid <= pend;
			if (pend) begin
				o_data <= next_filt;
			end
		end else begin
			o_valid <= i_valid; // [RULE_19]
			o_data  <= i_data;
		end
	end
endmodule

module ddc_chain #(
	parameter int          W         = 16,
	parameter logic [11:0] CTRL_ADDR = ddc_pkg::DDC_CTRL0_ADDR,
	parameter logic [11:0] STAT_ADDR = ddc_pkg::DDC_STAT0_ADDR,
	parameter int FIRST_COEF [6]  = ddc_pkg::DDC_FIRST_COEF,
	parameter int SECOND_COEF [6] = ddc_pkg::DDC_SECOND_COEF
) (
	// Clock and reset
	input  wire logic                i_core_clk,
	input  wire logic                i_rst_n,
	// Wishbone slave
	input  wire logic                i_wb_cyc,
	input  wire logic                i_wb_stb,
	input  wire logic                i_wb_we,
	input  wire logic [11:0]         i_wb_adr,
	input  wire logic [31:0]         i_wb_dat,
	input  wire logic [3:0]          i_wb_sel,
	output logic      [31:0]         o_wb_dat,
	output logic                     o_wb_ack,
	// Mixer samples in
	input  wire logic                i_valid,
	input  wire logic signed [W-1:0] i_data_i,
	input  wire logic signed [W-1:0] i_data_q,
	// Filtered samples out
	output logic                     o_valid,
	output logic signed [W-1:0]      o_data_i,
	output logic signed [W-1:0]      o_data_q,
	// Mixer mode
	output logic                     o_complex_input
);
	if (W < 8 || W > 32) begin : g_check
		$error("ddc_chain: W must lie in 8..32");
	end

	// Both windows must decode apart, or reads would alias
	if (CTRL_ADDR == STAT_ADDR) begin : g_addr_check
		$error("ddc_chain: CTRL_ADDR and STAT_ADDR must differ");
	end

	// Saturate a wide value to the sample width
	function automatic logic signed [W-1:0] sat_w(input longint v);
		return W'(ddc_pkg::ddc_clamp(v, W));
	endfunction

	// Engaged stages for a select code, first stage in bit 3
	function automatic logic [3:0] stage_mask(input logic [1:0] s);
		case (s)
			ddc_pkg::DDC_SEL_ALL:    return 4'hF;
			ddc_pkg::DDC_SEL_SECOND: return 4'h7;
			ddc_pkg::DDC_SEL_THIRD:  return 4'h3;
			default:                 return 4'h1;
		endcase
	endfunction

	logic [7:0]          ctrl;
	logic [15:0]         out_count;
	logic [1:0]          mix_phase;
	logic [3:0]          stages;
	logic                en_first;
	logic                en_second;
	logic                en_third;
	logic                c2r;
	logic                gain6;
	logic                req;
	logic [31:0]         next_rdata;
	logic signed [W-1:0] next_i;
	logic signed [W-1:0] next_q;

	logic                v1, v2, v3, v4q, v4;
	logic signed [W-1:0] d1i, d1q, d2i, d2q, d3i, d3q, d4i, d4q;

	wire logic [1:0] sel = ctrl[ddc_pkg::DDC_SEL_LSB +: 2]; // [RULE_17]

	// Stage engagement from the decimation select
	assign stages    = stage_mask(sel);
	assign en_first  = stages[3]; // [RULE_04]
	assign en_second = stages[2]; // [RULE_06]
	assign en_third  = stages[1]; // [RULE_08]
	assign c2r       = ctrl[ddc_pkg::DDC_C2R_BIT];
	assign gain6     = ctrl[ddc_pkg::DDC_GAIN_BIT];
	assign req       = i_wb_cyc && i_wb_stb && !o_wb_ack;

	// Register access, one wait state; bits outside the mask read zero
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			ctrl <= ddc_pkg::DDC_CTRL_RESET;
		end else if (req && i_wb_we && i_wb_sel[0] &&
			i_wb_adr == CTRL_ADDR) begin
			ctrl <= i_wb_dat[7:0] & ddc_pkg::DDC_CTRL_MASK; // [RULE_18]
		end
	end

	always_comb begin
		next_rdata = '0;
		if (i_wb_adr == CTRL_ADDR) begin
			next_rdata[7:0] = ctrl;
		end else if (i_wb_adr == STAT_ADDR) begin
			next_rdata[3:0] = stages; // [RULE_02]
			next_rdata[ddc_pkg::DDC_STAT_CNT_LSB +: 16] = out_count;
		end
	end

	// Unmapped addresses still answer, reading zero
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= '0;
		end else begin
			o_wb_ack <= req;
			if (req && !i_wb_we) begin
				o_wb_dat <= next_rdata;
			end
		end
	end

	// Registered copy lets the mixer switch on a clean edge
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_complex_input <= 1'b0;
		end else begin
			o_complex_input <= ctrl[ddc_pkg::DDC_CPLX_BIT]; // [RULE_18]
		end
	end

	// Cascade, first to final
	ddc_hb_stage #(.W(W), .NTAPS(ddc_pkg::DDC_FIRST_TAPS), // [RULE_03]
		.SHIFT(ddc_pkg::DDC_FIRST_SHIFT), .COEF(FIRST_COEF)) u_first_i (
		.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_enable(en_first),
		.i_decimate(1'b1), .i_valid(i_valid), .i_data(i_data_i),
		.o_valid(v1), .o_data(d1i)); // [RULE_01]
	ddc_hb_stage #(.W(W), .NTAPS(ddc_pkg::DDC_FIRST_TAPS),
		.SHIFT(ddc_pkg::DDC_FIRST_SHIFT), .COEF(FIRST_COEF)) u_first_q (
		.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_enable(en_first),
		.i_decimate(1'b1), .i_valid(i_valid), .i_data(i_data_q),
		.o_valid(), .o_data(d1q));
	ddc_hb_stage #(.W(W), .NTAPS(ddc_pkg::DDC_SECOND_TAPS), // [RULE_05]
		.SHIFT(ddc_pkg::DDC_SECOND_SHIFT), .COEF(SECOND_COEF)) u_second_i (
		.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_enable(en_second),
		.i_decimate(1'b1), .i_valid(v1), .i_data(d1i),
		.o_valid(v2), .o_data(d2i));
	ddc_hb_stage #(.W(W), .NTAPS(ddc_pkg::DDC_SECOND_TAPS),
		.SHIFT(ddc_pkg::DDC_SECOND_SHIFT), .COEF(SECOND_COEF)) u_second_q (
		.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_enable(en_second),
		.i_decimate(1'b1), .i_valid(v1), .i_data(d1q),
		.o_valid(), .o_data(d2q));
	ddc_hb_stage #(.W(W), .NTAPS(ddc_pkg::DDC_THIRD_TAPS), // [RULE_07]
		.SHIFT(ddc_pkg::DDC_THIRD_SHIFT),
		.COEF(ddc_pkg::DDC_THIRD_COEF)) u_third_i ( // [RULE_09]
		.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_enable(en_third),
		.i_decimate(1'b1), .i_valid(v2), .i_data(d2i),
		.o_valid(v3), .o_data(d3i));
	ddc_hb_stage #(.W(W), .NTAPS(ddc_pkg::DDC_THIRD_TAPS),
		.SHIFT(ddc_pkg::DDC_THIRD_SHIFT),
		.COEF(ddc_pkg::DDC_THIRD_COEF)) u_third_q (
		.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_enable(en_third),
		.i_decimate(1'b1), .i_valid(v2), .i_data(d2q),
		.o_valid(), .o_data(d3q));
	// Final stage tied on; real conversion drops its downsample
	ddc_hb_stage #(.W(W), .NTAPS(ddc_pkg::DDC_FINAL_TAPS), // [RULE_10]
		.SHIFT(ddc_pkg::DDC_FINAL_SHIFT),
		.COEF(ddc_pkg::DDC_FINAL_COEF)) u_final_i ( // [RULE_11]
		.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_enable(1'b1),
		.i_decimate(!c2r), .i_valid(v3), .i_data(d3i),
		.o_valid(v4), .o_data(d4i)); // [RULE_02] [RULE_14]
	ddc_hb_stage #(.W(W), .NTAPS(ddc_pkg::DDC_FINAL_TAPS),
		.SHIFT(ddc_pkg::DDC_FINAL_SHIFT),
		.COEF(ddc_pkg::DDC_FINAL_COEF)) u_final_q (
		.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_enable(1'b1),
		.i_decimate(!c2r), .i_valid(v3), .i_data(d3q),
		.o_valid(v4q), .o_data(d4q));

	// Gain, then quarter-rate upconversion
	always_comb begin
		logic signed [W-1:0] gi;
		logic signed [W-1:0] gq;
		gi = d4i;
		gq = d4q;
		if (gain6) begin
			// Saturate rather than wrap on the doubling
			gi = sat_w(longint'(d4i) <<< 1); // [RULE_12]
			gq = sat_w(longint'(d4q) <<< 1);
		end
		next_i = gi;
		next_q = gq;
		if (c2r) begin
			next_q = '0; // [RULE_16]
			case (mix_phase)
				2'h0: next_i = gi;
				2'h1: next_i = sat_w(-longint'(gq));
				2'h2: next_i = sat_w(-longint'(gi));
				2'h3: next_i = gq;
				default: next_i = gi;
			endcase // [RULE_15]
		end
	end

	// Phase restarts with the mode so the first real sample is in-phase
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n || !c2r) begin
			mix_phase <= '0;
		end else if (v4) begin
			mix_phase <= mix_phase + 2'h1; // [RULE_15]
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_valid  <= 1'b0;
			o_data_i <= '0;
			o_data_q <= '0;
		end else begin
			o_valid <= v4 && v4q;
			if (v4) begin
				o_data_i <= next_i;
				o_data_q <= next_q;
			end
		end
	end

	// Wraps silently; software must poll often enough to see progress
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			out_count <= '0;
		end else if (v4) begin
			out_count <= out_count + 16'h0001;
		end
	end
endmodule

// [ddc_chain_properties.sv]
// Checker of bus answers and output stream of one chain channel.
// Assumes it sees the ports of a ddc_chain instance only.
`timescale 1ns/1ps
module ddc_chain_props #(
	parameter int          W         = 16,
	parameter logic [11:0] CTRL_ADDR = 12'h310,
	parameter logic [11:0] STAT_ADDR = 12'h31C
) (
	input wire logic                i_core_clk,
	input wire logic                i_rst_n,
	input wire logic                i_wb_cyc,
	input wire logic                i_wb_stb,
	input wire logic                i_wb_we,
	input wire logic [11:0]         i_wb_adr,
	input wire logic [31:0]         i_wb_dat,
	input wire logic [3:0]          i_wb_sel,
	input wire logic [31:0]         o_wb_dat,
	input wire logic                o_wb_ack,
	input wire logic                i_valid,
	input wire logic                o_valid,
	input wire logic signed [W-1:0] o_data_q,
	input wire logic                o_complex_input
);
	// Shadow of ctrl, built from bus writes, since ctrl is not a port
	logic [7:0] shadow;
	logic [4:0] idle;
	logic [3:0] stat_exp;
	wire take = i_wb_cyc && i_wb_stb && !o_wb_ack;
	wire wr_c = take && i_wb_we && i_wb_adr == CTRL_ADDR && i_wb_sel[0];
	wire [1:0] s = shadow[1:0];
	assign stat_exp = s == 2'h3 ? 4'h1 : s == 2'h0 ? 4'h3 : s == 2'h1 ? 4'h7 : 4'hF;
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			shadow <= 8'h00;
		end else if (wr_c) begin
			shadow <= i_wb_dat[7:0] & ddc_pkg::DDC_CTRL_MASK;
		end
	end
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n || i_valid) begin
			idle <= 5'h00;
		end else if (idle != 5'h1F) begin
			idle <= idle + 5'h01;
		end
	end
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_rd(logic [11:0] a);
		take && !i_wb_we && i_wb_adr == a;
	endsequence
	sequence s_wr_ctrl;
		wr_c;
	endsequence
	property p_ack_req; take |=> o_wb_ack; endproperty
	property p_ack_cause; o_wb_ack |-> $past(take); endproperty
	property p_ctrl_rd;
		s_rd(CTRL_ADDR) |=> o_wb_ack && o_wb_dat == {24'h0, shadow};
	endproperty
	property p_unmapped;
		take && !i_wb_we && i_wb_adr != CTRL_ADDR && i_wb_adr != STAT_ADDR
			|=> o_wb_dat == 32'h0;
	endproperty
	property p_stat; s_rd(STAT_ADDR) |=> o_wb_dat[3:0] == stat_exp; endproperty
	property p_cplx;
		s_wr_ctrl |-> ##2 o_complex_input == $past(i_wb_dat[7], 2);
	endproperty
	property p_c2r_q; o_valid && shadow[3] |-> o_data_q == '0; endproperty
	property p_valid_gap; o_valid && !shadow[3] |=> !o_valid; endproperty
	property p_valid_cause; o_valid |-> idle < 5'h10; endproperty
	a_ack_req: assert property (p_ack_req) else $error("no ack");
	a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
	a_ctrl_rd: assert property (p_ctrl_rd) else $error("ctrl read");
	a_unmapped: assert property (p_unmapped) else $error("unmapped");
	a_stat: assert property (p_stat) else $error("stages");
	a_cplx: assert property (p_cplx) else $error("input mode");
	a_c2r_q: assert property (p_c2r_q) else $error("q kept");
	a_valid_gap: assert property (p_valid_gap) else $error("rate");
	a_valid_cause: assert property (p_valid_cause) else $error("stray");
endmodule
bind ddc_chain ddc_chain_props #(.W(W), .CTRL_ADDR(CTRL_ADDR),
	.STAT_ADDR(STAT_ADDR)) u_props (.i_core_clk(i_core_clk),
	.i_rst_n(i_rst_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
	.i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat),
	.i_wb_sel(i_wb_sel), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
	.i_valid(i_valid), .o_valid(o_valid), .o_data_q(o_data_q),
	.o_complex_input(o_complex_input));

// [ddc_mixer_model.sv]
// Mixer-side source: sends a burst of constant I/Q samples.
// Assumes levels are set before start and held during the burst.
`timescale 1ns/1ps
module ddc_mixer_model (
	// Clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_n,
	// Burst control
	input  wire logic        i_start,
	input  wire logic        i_slow,
	input  wire logic [15:0] i_count,
	input  wire logic [15:0] i_lvl_i,
	input  wire logic [15:0] i_lvl_q,
	// Samples
	output logic             o_valid,
	output logic [15:0]      o_data_i,
	output logic [15:0]      o_data_q,
	output logic             o_busy
);
	logic [15:0] left;
	logic        ph;
	wire fire = left != 16'h0 && (!i_slow || ph);
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			left <= 16'h0;
			ph <= 1'b0;
			o_valid <= 1'b0;
		end else begin
			ph <= ~ph;
			o_valid <= fire;
			left <= i_start ? i_count : left - 16'(fire);
		end
	end
	// Off-strobe lines show the inverse so stale data is never trusted
	assign o_data_i = o_valid ? i_lvl_i : ~i_lvl_i;
	assign o_data_q = o_valid ? i_lvl_q : ~i_lvl_q;
	assign o_busy = left != 16'h0 || o_valid;
endmodule

// [ddc_chain_bench.sv]
// Bench of one chain channel fed by the mixer-side source model.
// Assumes package, design, checker and source are compiled first.
`timescale 1ns/1ps
module ddc_chain_bench;
	localparam logic [11:0] CA = ddc_pkg::DDC_CTRL0_ADDR;
	localparam logic [11:0] SA = ddc_pkg::DDC_STAT0_ADDR;
	logic               i_core_clk = 1'b0;
	logic               i_rst_n = 1'b0;
	logic               cyc = 1'b0;
	logic               stb = 1'b0;
	logic               we = 1'b0;
	logic [11:0]        adr = 12'h000;
	logic [31:0]        wdat = 32'h0;
	logic [3:0]         sel = 4'h0;
	logic               start = 1'b0;
	logic               slow = 1'b0;
	logic [15:0]        cnt = 16'h0;
	logic [15:0]        lvl_i = 16'h0;
	logic [15:0]        lvl_q = 16'h0;
	logic [31:0]        rdat;
	logic               ack, s_valid, busy, o_valid, cplx;
	logic signed [15:0] s_i, s_q, o_i, o_q;
	logic signed [15:0] got_i[$];
	logic signed [15:0] got_q[$];
	int                 errors = 0;
	int                 check_count = 0;
	int                 seed = 32'h1b53c419;
	int                 nst[4] = '{1, 2, 3, 0};
	ddc_mixer_model u_src (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
		.i_start(start), .i_slow(slow), .i_count(cnt), .i_lvl_i(lvl_i),
		.i_lvl_q(lvl_q), .o_valid(s_valid), .o_data_i(s_i),
		.o_data_q(s_q), .o_busy(busy));
	ddc_chain u_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
		.i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack),
		.i_valid(s_valid), .i_data_i(s_i), .i_data_q(s_q),
		.o_valid(o_valid), .o_data_i(o_i), .o_data_q(o_q),
		.o_complex_input(cplx));
	always #5 i_core_clk = ~i_core_clk;
	always @(posedge i_core_clk) begin
		if (i_rst_n && o_valid === 1'b1) begin
			got_i.push_back(o_i);
			got_q.push_back(o_q);
		end
	end
	function automatic int sat(input int v);
		return v > 32767 ? 32767 : v < -32768 ? -32768 : v;
	endfunction
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t reg got %h want %h", $time, got, exp);
		end
	endtask
	task automatic cmp_smp(input logic signed [15:0] got, input int exp);
		check_count++;
		if (got !== 16'(exp)) begin
			errors++;
			$display("BAD %0t sample got %0d want %0d", $time, got, exp);
		end
	endtask
	task automatic wait_for(input int lim, output int n);
		n = 0;
		while (got_i.size() < 80 && n < lim) begin
			@(posedge i_core_clk);
			n++;
		end
		if (n == lim) begin
			errors++;
			print_verdict();
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [3:0] s, output logic [31:0] r);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		@(posedge i_core_clk);
		while (ack !== 1'b1 && n < 20) begin
			@(posedge i_core_clk);
			n++;
		end
		if (n == 20) begin
			errors++;
			print_verdict();
		end
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge i_core_clk);
	endtask
	task automatic do_reset();
		i_rst_n <= 1'b0;
		repeat (8) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		@(posedge i_core_clk);
		got_i.delete();
		got_q.delete();
	endtask
	// Constant levels let the unity-gain tables be checked exactly
	task automatic run_cfg(input logic [7:0] c);
		logic [31:0] r;
		int div, n, g, a, b, ea, eb, ok, v[4];
		do_reset();
		g = c[6] ? 2 : 1;
		div = 1 << (nst[c[1:0]] + (c[3] ? 0 : 1));
		a = $random(seed) % (c[3] ? 16000 : 30000);
		b = $random(seed) % (c[3] ? 16000 : 30000);
		lvl_i <= 16'(a);
		lvl_q <= 16'(b);
		bus(1'b1, CA, {24'h0, c}, 4'h1, r);
		bus(1'b0, CA, 32'h0, 4'hF, r);
		cmp_reg(r, {24'h0, c & 8'hCB});
		cmp_reg({31'h0, cplx}, {31'h0, c[7]});
		bus(1'b0, SA, 32'h0, 4'hF, r);
		cmp_reg({28'h0, r[3:0]}, (32'h2 << nst[c[1:0]]) - 32'h1);
		slow <= c[0];
		cnt <= 16'(80 * div);
		start <= 1'b1;
		@(posedge i_core_clk);
		start <= 1'b0;
		wait_for(4000, n);
		bus(1'b0, SA, 32'h0, 4'hF, r);
		cmp_reg({16'h0, r[31:16]}, 32'h50);
		cmp_reg(32'(got_i.size()), 32'h50);
		ea = sat(a * g);
		eb = sat(b * g);
		if (!c[3]) begin
			cmp_smp(got_i[$], ea);
			cmp_smp(got_q[$], eb);
		end else begin
			for (int k = 0; k < 4; k++) v[k] = got_i[got_i.size() - 4 + k];
			ok = (v[0] == ea && v[1] == -eb) || (v[0] == -eb && v[1] == -ea)
				|| (v[0] == -ea && v[1] == eb) || (v[0] == eb && v[1] == ea);
			cmp_reg(32'(ok && v[2] == -v[0] && v[3] == -v[1]), 32'h1);
			cmp_smp(got_q[$], 0);
		end
		$display("test ctrl %h done", c);
	endtask
	initial begin
		logic [31:0] r;
		logic        b;
		do_reset();
		bus(1'b0, CA, 32'h0, 4'hF, r);
		cmp_reg(r, 32'h0);
		bus(1'b1, CA, 32'hFF, 4'hE, r);
		bus(1'b1, SA, 32'hFFFFFFFF, 4'hF, r);
		bus(1'b0, SA, 32'h0, 4'hF, r);
		cmp_reg(r, 32'h3);
		bus(1'b1, 12'h314, 32'hFF, 4'hF, r);
		bus(1'b0, 12'h314, 32'h0, 4'hF, r);
		cmp_reg(r, 32'h0);
		bus(1'b0, CA, 32'h0, 4'hF, r);
		cmp_reg(r, 32'h0);
		$display("test registers done");
		// Real input always comes with the extra gain
		for (int k = 0; k < 8; k++) begin
			b = 1'($random(seed));
			run_cfg({b, k[2] | !b, {3{k[2]}}, 1'b0, 2'(k)});
		end
		run_cfg(8'h4B);
		run_cfg(8'hCA);
		print_verdict();
	end
endmodule
